/* File: core/external_bus_pkg.sv */
// Constants shared by the external bus unit and its helpers.
// Assumes one 100 MHz clock; two clock cycles make one CPU clock cycle.
package external_bus_pkg;

  // Clock rate and the half CPU cycle used for delayed chip selects.
  localparam int          CLK_PERIOD_PS    = 10000;
  localparam int          HALF_CPU_CYC_PS  = 10000;
  localparam int          CS_DELAY_CYC     = (HALF_CPU_CYC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Counts of clock cycles.
  localparam logic [3:0]  ALE_BASE_CYC     = 4'h0;
  localparam logic [3:0]  TRI_BASE_CYC     = 4'h0;
  localparam logic [3:0]  TRI_EXTRA_CYC    = 4'h1;

  // Field positions of a bus configuration word.
  localparam int          CFG_CYCLE_LSB    = 0;
  localparam int          CFG_CYCLE_W      = 4;
  localparam int          CFG_RWDELAY_BIT  = 4;
  localparam int          CFG_TRISTATE_BIT = 5;
  localparam int          CFG_TYPE_LSB     = 6;
  localparam int          CFG_READY_POL    = 8;
  localparam int          CFG_ALE_LONG_BIT = 9;
  localparam int          CFG_ACTIVE_BIT   = 10;
  localparam int          CFG_READY_EN_BIT = 12;
  localparam int          CFG_CS_EN_BIT    = 14;

  // Field positions of a window address select word.
  localparam int          SEL_SIZE_LSB     = 0;
  localparam int          SEL_START_LSB    = 4;

  // Bus types held in a configuration word.
  localparam logic [1:0]  BUS_DEMUX_8      = 2'h0;
  localparam logic [1:0]  BUS_MUX_8        = 2'h1;
  localparam logic [1:0]  BUS_DEMUX_16     = 2'h2;
  localparam logic [1:0]  BUS_MUX_16       = 2'h3;

  // Address space restriction codes.
  localparam logic [1:0]  SPACE_16M        = 2'h0;
  localparam logic [1:0]  SPACE_1M         = 2'h1;
  localparam logic [1:0]  SPACE_256K       = 2'h2;
  localparam logic [1:0]  SPACE_64K        = 2'h3;
  localparam logic [7:0]  UPPER_MASK_16M   = 8'hFF;
  localparam logic [7:0]  UPPER_MASK_1M    = 8'h0F;
  localparam logic [7:0]  UPPER_MASK_256K  = 8'h03;
  localparam logic [7:0]  UPPER_MASK_64K   = 8'h00;

  localparam int          NUM_WINDOWS      = 4;
  localparam logic [4:0]  CS_NONE          = 5'h1F;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DELAY = 3'b010,
    ST_WAIT  = 3'b011,
    ST_READY = 3'b100,
    ST_RECOV = 3'b101,
    ST_HOLD  = 3'b110
  } bus_state_t;

endpackage : external_bus_pkg

/* File: core/window_match.sv */
// Address comparator for one address window.
// Assumes the select word holds a 4 KB aligned start and a power-of-two size code.
`timescale 1ns/1ps
module window_match
  import external_bus_pkg::*;
(
  // Access address and window description.
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_select,
  input  wire logic        i_active,
  // Match result.
  output logic             o_hit
);

  wire  [3:0]  size_code = i_select[SEL_START_LSB-1:SEL_SIZE_LSB];
  wire  [11:0] start     = i_select[15:SEL_START_LSB];
  wire  [11:0] mask      = 12'hFFF << size_code;

  assign o_hit = i_active && ((i_addr[23:12] & mask) == (start & mask));

endmodule : window_match

/* File: core/phase_timer.sv */
// Down counter that times the phases of one bus cycle.
// Assumes a load is issued on the edge that enters each timed phase.
`timescale 1ns/1ps
module phase_timer
  import external_bus_pkg::*;
(
  // Clock and reset.
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Load and status.
  input  wire logic       i_load,
  input  wire logic [3:0] i_value,
  output logic            o_zero
);

  logic [3:0] count_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count_reg <= 4'h0;
    end else if (i_load) begin
      count_reg <= i_value;
    end else if (count_reg != 4'h0) begin
      count_reg <= count_reg - 4'h1;
    end
  end

  assign o_zero = (count_reg == 4'h0);

endmodule : phase_timer

/* File: core/external_bus_unit.sv */
// External bus unit: runs every external access of the CPU over the bus pins.
// Assumes all inputs are synchronous to i_ref_clk and configuration is static during a cycle.
//
// Functional notes
// - Single chip or mux/demux, 8/16-bit data, 16 to 24 address bits.
// - Demux: address on address-only port, data on lower port, low byte for 8-bit.
// - Mux: address then data share the lower bus port within one cycle.
// - Cycle time, tri-state time, ALE length and read/write delay are programmable.
// - Four windows, each a select word plus its own bus configuration.
// - On overlap window four beats three and window two beats one.
// - Accesses outside all windows use the default bus configuration.
// - Five active-low chip selects: four windows plus default.
// - With ready enabled, the cycle ends only on the active ready level.
// - Ready level select: 0 ends on low ready, 1 ends on high ready.
// - Arbitration enable bit hands request, acknowledge and hold pins to the unit.
// - After reset the unit is arbitration master, acknowledge pin is an output.
// - With arbitration enabled, port 6 pin 7 direction set to 1 makes the acknowledge pin an input.
// - Address space 16M, 1M, 256K or 64K drives 8, 4, 2 or 0 upper lines.
// - By default chip selects change half a CPU cycle after ALE rises.
// - With select timing choice set, chip selects change with ALE and address.
`timescale 1ns/1ps
module external_bus_unit
  import external_bus_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Configuration.
  input  wire logic        i_single_chip,
  input  wire logic [15:0] i_default_bus_config,
  input  wire logic [63:0] i_window_bus_config,
  input  wire logic [63:0] i_window_address_select,
  input  wire logic [1:0]  i_addr_space_sel,
  input  wire logic        i_select_timing_choice,
  input  wire logic        i_arbitration_enable_bit,
  input  wire logic        i_port6_pin7_direction,
  // CPU request and answer.
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [23:0] i_addr,
  input  wire logic [15:0] i_wdata,
  output logic             o_ack,
  output logic [15:0]      o_rdata,
  output logic             o_busy,
  // Bus control pins.
  output logic             o_ale,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic [4:0]       o_chip_select_lines_n,
  output logic             o_ctrl_oe,
  input  wire logic        i_ready,
  // Address and data pins.
  output logic [15:0]      o_address_only_port,
  output logic [7:0]       o_upper_addr,
  input  wire logic [15:0] i_lower_bus_port,
  output logic [15:0]      o_lower_bus_port,
  output logic [1:0]       o_lower_bus_port_oe,
  // Arbitration pins.
  input  wire logic        i_hold_n,
  output logic             o_bus_request_out_n,
  input  wire logic        i_hold_acknowledge_pin_n,
  output logic             o_hold_acknowledge_pin_n,
  output logic             o_hold_acknowledge_pin_oe
);

  bus_state_t  state_reg;
  bus_state_t  state_next;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic        we_reg;
  logic [15:0] cfg_reg;
  logic [2:0]  idx_reg;
  logic        ack_reg;
  logic [15:0] rdata_reg;
  logic        ale_reg;
  logic        rd_n_reg;
  logic        wr_n_reg;
  logic [4:0]  cs_n_reg;
  logic        ctrl_oe_reg;
  logic [15:0] aport_reg;
  logic [7:0]  upper_reg;
  logic [15:0] lbp_reg;
  logic [1:0]  lbp_oe_reg;
  logic        bus_request_out_n_reg;
  logic        hold_acknowledge_pin_n_reg;
  logic        hold_acknowledge_pin_oe_reg;
  logic        busy_reg;

  // Window decode.
  logic [NUM_WINDOWS-1:0] win_hit;
  wire  [15:0]            cfg_arr [0:NUM_WINDOWS];

  assign cfg_arr[0] = i_default_bus_config;

  genvar g;
  generate
    for (g = 0; g < NUM_WINDOWS; g++) begin : g_win
      assign cfg_arr[g+1] = i_window_bus_config[16*g +: 16];
      window_match u_match (
        .i_addr   (i_addr),
        .i_select (i_window_address_select[16*g +: 16]),
        .i_active (i_window_bus_config[16*g + CFG_ACTIVE_BIT]),
        .o_hit    (win_hit[g])
      );
    end
  endgenerate

  // Window four over three, three over two, two over one, else default.
  wire [2:0] win_idx = win_hit[3] ? 3'h4 :
                       win_hit[2] ? 3'h3 :
                       win_hit[1] ? 3'h2 :
                       win_hit[0] ? 3'h1 : 3'h0;
  wire [15:0] win_cfg = cfg_arr[win_idx];

  // Fields of the configuration latched for the running cycle; the ALE length bit comes from the newly decoded window.
  wire [3:0] cfg_cycle   = cfg_reg[CFG_CYCLE_LSB +: CFG_CYCLE_W];
  wire       cfg_rwdel   = cfg_reg[CFG_RWDELAY_BIT];
  wire       cfg_tri     = cfg_reg[CFG_TRISTATE_BIT];
  wire [1:0] cfg_type    = cfg_reg[CFG_TYPE_LSB +: 2];
  wire       cfg_rdy_pol = cfg_reg[CFG_READY_POL];
  wire       cfg_rdy_en  = cfg_reg[CFG_READY_EN_BIT];
  wire       cfg_cs_en   = cfg_reg[CFG_CS_EN_BIT];
  wire       new_ale_ext = win_cfg[CFG_ALE_LONG_BIT];
  wire       mux_mode    = (cfg_type == BUS_MUX_8) || (cfg_type == BUS_MUX_16);
  wire       byte_mode   = (cfg_type == BUS_MUX_8) || (cfg_type == BUS_DEMUX_8);

  // Arbitration: master keeps the bus unless held, slave needs acknowledge in.
  wire arb_on     = i_arbitration_enable_bit;
  wire slave_mode = arb_on && i_port6_pin7_direction;
  wire hold_req   = arb_on && !slave_mode && !i_hold_n;
  wire own_bus    = !slave_mode || !i_hold_acknowledge_pin_n;

  // Phase timer shared by the address, wait and recovery phases.
  logic       tmr_load;
  logic [3:0] tmr_value;
  logic       tmr_zero;

  phase_timer u_timer (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (tmr_load),
    .i_value   (tmr_value),
    .o_zero    (tmr_zero)
  );

  wire take      = (state_reg == ST_IDLE) && i_req && !i_single_chip && !hold_req && own_bus;
  wire ready_hit = (i_ready == cfg_rdy_pol);
  wire finish    = ((state_reg == ST_WAIT) && tmr_zero && !cfg_rdy_en) ||
                   ((state_reg == ST_READY) && ready_hit);
  wire local_ack = (state_reg == ST_IDLE) && i_req && i_single_chip;

  // Next state and timer loads.
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_value  = 4'h0;
    case (state_reg)
      ST_IDLE: begin
        if (hold_req) begin
          state_next = ST_HOLD;
        end else if (take) begin
          state_next = ST_ADDR;
          tmr_load   = 1'b1;
          tmr_value  = ALE_BASE_CYC + {3'h0, new_ale_ext};
        end
      end
      ST_ADDR: begin
        if (tmr_zero) begin
          if (cfg_rwdel) begin
            state_next = ST_DELAY;
          end else begin
            state_next = ST_WAIT;
            tmr_load   = 1'b1;
            tmr_value  = cfg_cycle;
          end
        end
      end
      ST_DELAY: begin
        state_next = ST_WAIT;
        tmr_load   = 1'b1;
        tmr_value  = cfg_cycle;
      end
      ST_WAIT: begin
        if (tmr_zero) begin
          if (cfg_rdy_en) begin
            state_next = ST_READY;
          end else begin
            state_next = ST_RECOV;
            tmr_load   = 1'b1;
            tmr_value  = cfg_tri ? TRI_BASE_CYC : TRI_BASE_CYC + TRI_EXTRA_CYC;
          end
        end
      end
      ST_READY: begin
        if (ready_hit) begin
          state_next = ST_RECOV;
          tmr_load   = 1'b1;
          tmr_value  = cfg_tri ? TRI_BASE_CYC : TRI_BASE_CYC + TRI_EXTRA_CYC;
        end
      end
      ST_RECOV: begin
        if (tmr_zero) begin
          state_next = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!hold_req) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Values that the pins take on the next edge.
  wire [23:0] addr_next   = take ? i_addr : addr_reg;
  wire [15:0] cfg_next    = take ? win_cfg : cfg_reg;
  wire [2:0]  idx_next    = take ? win_idx : idx_reg;
  wire        cs_en_next  = cfg_next[CFG_CS_EN_BIT];
  wire        in_strobe   = (state_next == ST_WAIT) || (state_next == ST_READY);
  wire        in_active   = (state_next != ST_IDLE) && (state_next != ST_HOLD);
  wire        we_next     = take ? i_we : we_reg;

  wire [7:0] upper_mask = (i_addr_space_sel == SPACE_16M)  ? UPPER_MASK_16M  :
                          (i_addr_space_sel == SPACE_1M)   ? UPPER_MASK_1M   :
                          (i_addr_space_sel == SPACE_256K) ? UPPER_MASK_256K :
                                                             UPPER_MASK_64K;

  wire [4:0] cs_onehot  = CS_NONE & ~(5'h01 << idx_next);
  // With the timing choice set, selects move on the same edge as ALE and address.
  wire cs_assert_now    = i_select_timing_choice ? (state_next == ST_ADDR) && take
                                                 : (state_reg == ST_ADDR) &&
                                                   (cs_n_reg == CS_NONE);
  wire [4:0] cs_next    = !in_active   ? CS_NONE :
                          cs_assert_now ? (cs_en_next ? cs_onehot : CS_NONE) :
                                          cs_n_reg;

  wire next_mux   = (cfg_next[CFG_TYPE_LSB +: 2] == BUS_MUX_8) ||
                    (cfg_next[CFG_TYPE_LSB +: 2] == BUS_MUX_16);
  wire next_byte  = (cfg_next[CFG_TYPE_LSB +: 2] == BUS_MUX_8) ||
                    (cfg_next[CFG_TYPE_LSB +: 2] == BUS_DEMUX_8);
  wire addr_phase = (state_next == ST_ADDR);
  wire data_out   = we_next && in_active && !addr_phase && (state_next != ST_RECOV);
  wire [15:0] wdata_next = take ? i_wdata : wdata_reg;
  wire [15:0] lbp_next   = (addr_phase && next_mux) ? addr_next[15:0] :
                           next_byte ? {8'h00, wdata_next[7:0]} : wdata_next;
  wire [1:0]  lbp_oe_next = (addr_phase && next_mux) ? 2'h3 :
                            data_out ? (next_byte ? 2'h1 : 2'h3) : 2'h0;
  wire [15:0] aport_next  = next_mux ? 16'h0000 : addr_next[15:0];
  wire [15:0] rd_capture  = byte_mode ? {8'h00, i_lower_bus_port[7:0]} : i_lower_bus_port;

  // Arbitration pins: master answers a hold, slave requests when it lacks the bus.
  wire bus_request_out_next    = arb_on && (slave_mode ? (i_req && !own_bus && state_reg == ST_IDLE)
                                            : (state_next == ST_HOLD && i_req));
  wire hold_acknowledge_pin_next    = arb_on && !slave_mode && (state_next == ST_HOLD);
  wire hold_acknowledge_pin_oe_next = !slave_mode;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      addr_reg  <= 24'h000000;
      wdata_reg <= 16'h0000;
      we_reg    <= 1'b0;
      cfg_reg   <= 16'h0000;
      idx_reg   <= 3'h0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      we_reg    <= we_next;
      cfg_reg   <= cfg_next;
      idx_reg   <= idx_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
      busy_reg  <= 1'b0;
    end else begin
      ack_reg   <= finish || local_ack;
      rdata_reg <= (finish && !we_reg) ? rd_capture :
                   local_ack ? 16'h0000 : rdata_reg;
      busy_reg  <= in_active;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ale_reg     <= 1'b0;
      rd_n_reg    <= 1'b1;
      wr_n_reg    <= 1'b1;
      cs_n_reg    <= CS_NONE;
      ctrl_oe_reg <= 1'b1;
      aport_reg   <= 16'h0000;
      upper_reg   <= 8'h00;
      lbp_reg     <= 16'h0000;
      lbp_oe_reg  <= 2'h0;
    end else begin
      ale_reg     <= addr_phase;
      rd_n_reg    <= !(in_strobe && !we_next);
      wr_n_reg    <= !(in_strobe && we_next);
      cs_n_reg    <= cs_next;
      ctrl_oe_reg <= (state_next != ST_HOLD);
      aport_reg   <= aport_next;
      upper_reg   <= addr_next[23:16] & upper_mask;
      lbp_reg     <= lbp_next;
      lbp_oe_reg  <= lbp_oe_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bus_request_out_n_reg  <= 1'b1;
      hold_acknowledge_pin_n_reg  <= 1'b1;
      hold_acknowledge_pin_oe_reg <= 1'b1;
    end else begin
      bus_request_out_n_reg  <= !bus_request_out_next;
      hold_acknowledge_pin_n_reg  <= !hold_acknowledge_pin_next;
      hold_acknowledge_pin_oe_reg <= hold_acknowledge_pin_oe_next;
    end
  end

  assign o_ack                     = ack_reg;
  assign o_rdata                   = rdata_reg;
  assign o_busy                    = busy_reg;
  assign o_ale                     = ale_reg;
  assign o_rd_n                    = rd_n_reg;
  assign o_wr_n                    = wr_n_reg;
  assign o_chip_select_lines_n     = cs_n_reg;
  assign o_ctrl_oe                 = ctrl_oe_reg;
  assign o_address_only_port       = aport_reg;
  assign o_upper_addr              = upper_reg;
  assign o_lower_bus_port          = lbp_reg;
  assign o_lower_bus_port_oe       = lbp_oe_reg;
  assign o_bus_request_out_n       = bus_request_out_n_reg;
  assign o_hold_acknowledge_pin_n  = hold_acknowledge_pin_n_reg;
  assign o_hold_acknowledge_pin_oe = hold_acknowledge_pin_oe_reg;

endmodule : external_bus_unit

/* File: verification/external_bus_assertions.sv */
// Checks on the pins of the external bus unit.
// Assumes a bind to external_bus_unit and static configuration.
`timescale 1ns/1ps
module external_bus_assertions
  import external_bus_pkg::*;
(
  // Clock, reset and configuration.
  input  logic        i_ref_clk,
  input  logic        i_rst,
  input  logic        i_single_chip,
  input  logic [15:0] i_default_bus_config,
  input  logic [63:0] i_window_bus_config,
  input  logic [1:0]  i_addr_space_sel,
  input  logic        i_select_timing_choice,
  input  logic        i_arbitration_enable_bit,
  input  logic        i_port6_pin7_direction,
  input  logic        i_ready,
  // Observed outputs.
  input  logic        o_ale,
  input  logic        o_rd_n,
  input  logic        o_wr_n,
  input  logic [4:0]  o_chip_select_lines_n,
  input  logic        o_ctrl_oe,
  input  logic [7:0]  o_upper_addr,
  input  logic [1:0]  o_lower_bus_port_oe,
  input  logic        o_hold_acknowledge_pin_n,
  input  logic        o_hold_acknowledge_pin_oe
);
  wire [7:0] space_mask = (i_addr_space_sel == SPACE_1M) ? UPPER_MASK_1M :
                          (i_addr_space_sel == SPACE_256K) ? UPPER_MASK_256K :
                          (i_addr_space_sel == SPACE_64K) ? UPPER_MASK_64K : UPPER_MASK_16M;
  wire       strobe     = !o_rd_n || !o_wr_n;
  // Ready-gated strobe of the default or window four select while ready is inactive.
  wire       stall      = (!o_chip_select_lines_n[0] && i_default_bus_config[12] &&
                           i_ready != i_default_bus_config[8]) ||
                          (!o_chip_select_lines_n[4] && i_window_bus_config[60] &&
                           i_ready != i_window_bus_config[56]);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_cs_single; $countones(~o_chip_select_lines_n) <= 1; endproperty
  a_cs_single: assert property (p_cs_single) else $error("two selects active");
  property p_upper_mask; o_ale |-> (o_upper_addr & ~space_mask) == 8'h00; endproperty
  a_upper_mask: assert property (p_upper_mask) else $error("upper not masked");
  property p_cs_early;
    $rose(o_ale) && i_select_timing_choice |-> o_chip_select_lines_n != CS_NONE;
  endproperty
  a_cs_early: assert property (p_cs_early) else $error("select late with ALE");
  property p_cs_late;
    $rose(o_ale) && !i_select_timing_choice |->
      o_chip_select_lines_n == CS_NONE ##1 o_chip_select_lines_n != CS_NONE;
  endproperty
  a_cs_late: assert property (p_cs_late) else $error("select not delayed");
  property p_single_quiet;
    i_single_chip && $past(i_single_chip) |-> !o_ale && o_rd_n && o_wr_n;
  endproperty
  a_single_quiet: assert property (p_single_quiet) else $error("pins move in single chip");
  property p_master;
    !i_arbitration_enable_bit || !i_port6_pin7_direction |=> o_hold_acknowledge_pin_oe;
  endproperty
  a_master: assert property (p_master) else $error("acknowledge undriven");
  property p_slave;
    i_arbitration_enable_bit && i_port6_pin7_direction |=> !o_hold_acknowledge_pin_oe;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives acknowledge");
  property p_hold_release;
    !o_hold_acknowledge_pin_n && o_hold_acknowledge_pin_oe |->
      !o_ctrl_oe && o_lower_bus_port_oe == 2'h0;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("bus driven in hold");
  property p_ready_wait; strobe && stall |=> strobe; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ended without ready");
endmodule : external_bus_assertions

/* File: verification/bus_memory_model.sv */
// Memory with a ready pin on the external bus.
// Assumes the unit drives a zero address-only port in mux modes.
`timescale 1ns/1ps
module bus_memory_model (
  // Clock.
  input  logic        i_ref_clk,
  // Bus pins driven by the unit.
  input  logic        i_ale,
  input  logic        i_rd_n,
  input  logic        i_wr_n,
  input  logic [4:0]  i_cs_n,
  input  logic [15:0] i_addr_port,
  input  logic [15:0] i_data_out,
  input  logic [1:0]  i_data_oe,
  // Behaviour set by the bench.
  input  logic [3:0]  i_ready_delay,
  input  logic        i_ready_level,
  // Pins driven by the model.
  output logic [15:0] o_data_in,
  output logic        o_ready
);
  logic [15:0] mem [0:255];
  logic [15:0] last_reg = 16'h0000;
  logic [7:0]  addr_reg = 8'h00;
  logic [3:0]  wait_reg = 4'h0;
  wire logic   sel      = i_cs_n != 5'h1F;
  wire logic   strobe   = !i_rd_n || !i_wr_n;
  // A released data bus shows the inverse of its last value.
  assign o_data_in = (sel && !i_rd_n) ? mem[addr_reg] : ~last_reg;
  assign o_ready   = i_ready_level ^ !(strobe && wait_reg >= i_ready_delay);
  always @(posedge i_ref_clk) begin
    last_reg <= o_data_in;
    wait_reg <= strobe ? wait_reg + 4'h1 : 4'h0;
    if (i_ale) begin
      addr_reg <= (i_addr_port != 16'h0000) ? i_addr_port[7:0] : i_data_out[7:0];
    end
    if (sel && !i_wr_n) begin
      if (i_data_oe[0]) mem[addr_reg][7:0] <= i_data_out[7:0];
      if (i_data_oe[1]) mem[addr_reg][15:8] <= i_data_out[15:8];
    end
  end
endmodule : bus_memory_model

/* File: verification/testbench.sv */
// Self-checking bench for the external bus unit.
// Assumes the checker and model are compiled first.
`timescale 1ns/1ps
module testbench import external_bus_pkg::*;;
  typedef struct packed { logic is_rd; logic [15:0] data; logic [4:0] cs; } note_t;
  localparam logic [23:0] ADDR_TAB [5] = '{24'h010802, 24'h018004, 24'h020106, 24'h028008,
                                           24'h03000A};
  localparam logic [4:0]  CS_TAB [5]   = '{5'h1B, 5'h1D, 5'h0F, 5'h17, 5'h1E};
  logic        i_ref_clk = 1'h0, i_rst = 1'h1, i_single_chip = 1'h0, i_req = 1'h0, i_we = 1'h0;
  logic        i_select_timing_choice = 1'h0, i_arbitration_enable_bit = 1'h0;
  logic        i_port6_pin7_direction = 1'h0, i_hold_n = 1'h1, i_hold_acknowledge_pin_n = 1'h1;
  logic [15:0] i_default_bus_config = 16'h5480, i_wdata = 16'h0000;
  logic [63:0] i_window_bus_config = 64'h0, i_window_address_select = 64'h0;
  logic [1:0]  i_addr_space_sel = 2'h0;
  logic [23:0] i_addr = 24'h0;
  logic [3:0]  ready_delay = 4'h0;
  logic        ready_level = 1'h0;
  wire logic   o_ack, o_busy, o_ale, o_rd_n, o_wr_n, o_ctrl_oe, i_ready, o_bus_request_out_n;
  wire logic   o_hold_acknowledge_pin_n, o_hold_acknowledge_pin_oe;
  wire  [15:0] o_rdata, o_address_only_port, i_lower_bus_port, o_lower_bus_port;
  wire  [4:0]  o_chip_select_lines_n;
  wire  [7:0]  o_upper_addr;
  wire  [1:0]  o_lower_bus_port_oe;
  note_t       notes [$];
  logic [4:0]  seen_cs = 5'h1F;
  int          error_cnt = 0, cmp_count = 0, cycles = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  external_bus_unit i_external_bus_unit (.i_ref_clk, .i_rst, .i_single_chip,
    .i_default_bus_config, .i_window_bus_config, .i_window_address_select, .i_addr_space_sel,
    .i_select_timing_choice, .i_arbitration_enable_bit, .i_port6_pin7_direction, .i_req,
    .i_we, .i_addr, .i_wdata, .o_ack, .o_rdata, .o_busy, .o_ale, .o_rd_n, .o_wr_n,
    .o_chip_select_lines_n, .o_ctrl_oe, .i_ready, .o_address_only_port, .o_upper_addr,
    .i_lower_bus_port, .o_lower_bus_port, .o_lower_bus_port_oe, .i_hold_n,
    .o_bus_request_out_n, .i_hold_acknowledge_pin_n, .o_hold_acknowledge_pin_n,
    .o_hold_acknowledge_pin_oe);
  bus_memory_model i_bus_memory_model (.i_ref_clk, .i_ale(o_ale), .i_rd_n(o_rd_n),
    .i_wr_n(o_wr_n), .i_cs_n(o_chip_select_lines_n), .i_addr_port(o_address_only_port),
    .i_data_out(o_lower_bus_port), .i_data_oe(o_lower_bus_port_oe),
    .i_ready_delay(ready_delay), .i_ready_level(ready_level), .o_data_in(i_lower_bus_port),
    .o_ready(i_ready));

  task automatic finish_test();
    $display("TB: %0d comparisons, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic fail(input string msg);
    error_cnt++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask : fail

  task automatic check_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) fail(what);
  endtask : check_bit

  task automatic check_note(input note_t n);
    cmp_count++;
    if (seen_cs !== n.cs || (n.is_rd && o_rdata !== n.data)) fail("access select or data");
    seen_cs = CS_NONE;
  endtask : check_note

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick

  task automatic start_req(input logic we, input logic [23:0] a, input logic [15:0] d, exp,
                           input logic [4:0] cs);
    notes.push_back('{!we, exp, cs});
    i_we = we;
    i_addr = a;
    i_wdata = d;
    i_req = 1'h1;
  endtask : start_req

  task automatic wait_ack();
    int n = 0;
    while (o_ack !== 1'h1 && n < 60) begin
      tick(1);
      n++;
    end
    if (n >= 60) fail("no answer");
    i_req = 1'h0;
    tick(1);
  endtask : wait_ack

  // Answers are checked in order.
  always @(negedge i_ref_clk) begin
    if (o_chip_select_lines_n !== CS_NONE) seen_cs = o_chip_select_lines_n;
    if (o_ack === 1'h1) check_note(notes.pop_front());
  end

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("run timed out");
      finish_test();
    end
  end

  initial begin
    logic [15:0] d;
    logic        narrow;
    void'($urandom(81670));
    tick(10);
    i_rst = 1'h0;
    i_window_address_select = 64'h0200_0204_0100_0104;
    i_window_bus_config = 64'h5580_4440_4400_44C0;
    for (int p = 0; p < 4; p++) begin
      i_select_timing_choice = p[0];
      i_addr_space_sel = 2'(p);
      i_default_bus_config = 16'h5400 | 16'(p << 6) | (16'($urandom) & 16'h023F);
      ready_delay = 4'(p);
      for (int w = 0; w < 5; w++) begin
        narrow = (w == 0 || w == 3 || (w == 4 && p < 2));
        ready_level = (w == 2);
        d = 16'($urandom);
        start_req(1'h1, ADDR_TAB[w], d, 16'h0000, CS_TAB[w]);
        wait_ack();
        start_req(1'h0, ADDR_TAB[w], 16'h0000, narrow ? {8'h00, d[7:0]} : d, CS_TAB[w]);
        wait_ack();
      end
      $display("TB: window test %0d done", p);
    end
    i_arbitration_enable_bit = 1'h1;
    i_hold_n = 1'h0;
    tick(3);
    check_bit(o_hold_acknowledge_pin_n, 1'h0, "hold not granted");
    check_bit(o_ctrl_oe, 1'h0, "pins kept in hold");
    start_req(1'h0, ADDR_TAB[4], 16'h0000, d, CS_TAB[4]);
    tick(4);
    check_bit(o_busy, 1'h0, "access ran in hold");
    check_bit(o_bus_request_out_n, 1'h0, "no bus request");
    i_hold_n = 1'h1;
    wait_ack();
    $display("TB: hold test done");
    i_port6_pin7_direction = 1'h1;
    tick(2);
    check_bit(o_hold_acknowledge_pin_oe, 1'h0, "slave drives acknowledge");
    start_req(1'h1, ADDR_TAB[4], 16'h1234, 16'h0000, CS_TAB[4]);
    tick(4);
    check_bit(o_busy, 1'h0, "slave ran ungranted");
    check_bit(o_bus_request_out_n, 1'h0, "slave no request");
    i_hold_acknowledge_pin_n = 1'h0;
    wait_ack();
    i_hold_acknowledge_pin_n = 1'h1;
    i_port6_pin7_direction = 1'h0;
    i_arbitration_enable_bit = 1'h0;
    tick(2);
    check_bit(o_hold_acknowledge_pin_oe, 1'h1, "master not restored");
    $display("TB: arbitration test done");
    i_single_chip = 1'h1;
    tick(1);
    start_req(1'h1, ADDR_TAB[0], 16'hBEEF, 16'h0000, CS_NONE);
    wait_ack();
    i_single_chip = 1'h0;
    tick(5);
    check_bit(notes.size() == 0, 1'h1, "access left unanswered");
    $display("TB: single chip test done");
    finish_test();
  end
endmodule : testbench

bind external_bus_unit external_bus_assertions i_external_bus_assertions (.i_ref_clk, .i_rst,
  .i_single_chip, .i_default_bus_config, .i_window_bus_config, .i_addr_space_sel,
  .i_select_timing_choice, .i_arbitration_enable_bit, .i_port6_pin7_direction, .i_ready,
  .o_ale, .o_rd_n, .o_wr_n, .o_chip_select_lines_n, .o_ctrl_oe, .o_upper_addr,
  .o_lower_bus_port_oe, .o_hold_acknowledge_pin_n, .o_hold_acknowledge_pin_oe);
